// ---- dynamic_vid_reference_stepper.v ----
`timescale 1ns/1ps
`include "vid_stepper_consts.vh"

// Behaviour
// - mask over/under voltage during transitions
// - step is one LSB, 12.5mV or 25mV
// - fine: sample on rise of 3xFsw clock, confirm on fall
// - fine: step 12.5mV per sampling cycle from next rise
// - fine: ignore codes mid-transition, resume next rise
// - fine: large jumps still one step per cycle
// - coarse: sample on rise of Fsw clock, confirm fall
// - coarse: step 25mV per cycle from next rise
// - coarse: ignore codes mid-transition, resume next rise
// - coarse: large jumps one step per switching cycle
// - all-ones low code: switches off, restart on exit
// - coarse: grounded bit five adds 25mV offset
module dynamic_vid_reference_stepper #(
   parameter FSW_KHZ = `FSW_KHZ_DEFAULT
) (
   input  wire                mclk,
   input  wire                rst,
   input  wire [`CODE_W-1:0]  voltage_code_inputs,
   input  wire                dac_table_select,
   input  wire                soft_start_done_in,
   output reg  [`CODE_W-1:0]  ref_code_r,
   output reg  [`CODE_W-1:0]  target_code_r,
   output reg  [15:0]         step_size_uv_r,
   output reg  [15:0]         ref_offset_uv_r,
   output reg                 transition_active_r,
   output wire                over_voltage_protect_en,
   output wire                under_voltage_protect_en,
   output reg                 switches_enable_r,
   output wire                soft_start_done,
   output reg                 restart_pulse_r,
   output reg                 code_sampling_clock_r
);

   // half periods of the sampling clock less one, as terminal counts in mclk cycles; the longest time rounds down
   localparam integer HALF_FINE_I   = `CLK_KHZ / (FSW_KHZ * `FINE_CLK_MULT * 2) - 1;
   localparam integer HALF_COARSE_I = `CLK_KHZ / (FSW_KHZ * `COARSE_CLK_MULT * 2) - 1;
   // cut to the divider width on purpose; very slow switching rates would wrap
   localparam [`DIV_W-1:0] HALF_FINE   = HALF_FINE_I[`DIV_W-1:0];
   localparam [`DIV_W-1:0] HALF_COARSE = HALF_COARSE_I[`DIV_W-1:0];
   // one table LSB at the code width
   localparam [`CODE_W-1:0] ONE_LSB = {{(`CODE_W-1){1'b0}}, 1'b1};

   // one-hot states
   localparam [3:0] ST_INIT    = 4'h1;
   localparam [3:0] ST_MONITOR = 4'h2;
   localparam [3:0] ST_CONFIRM = 4'h4;
   localparam [3:0] ST_STEP    = 4'h8;

   reg  [3:0]          state_r;
   reg  [3:0]          state_nxt;
   reg                 fine_mode_r;
   reg  [`DIV_W-1:0]   div_cnt_r;
   reg  [`CODE_W-1:0]  sampled_code_r;
   reg                 no_code_r;
   reg  [`CODE_W-1:0]  ref_code_nxt;
   reg  [`CODE_W-1:0]  target_code_nxt;
   reg                 active_nxt;

   wire [`DIV_W-1:0]   half_period;
   wire                half_done;
   wire                rise_evt;
   wire                fall_evt;
   wire [`CODE_W-1:0]  code_eff;
   wire                no_code;
   wire [`CODE_W-1:0]  code_init;
   wire [`CODE_W-1:0]  ref_stepped;
   wire                step_up;
   wire                at_target;
   wire                sample_ok;
   wire                confirm_ok;
   wire                code_exit;

   // fine table uses all six bits; coarse uses five, bit five being the offset select
   assign code_eff = fine_mode_r ? voltage_code_inputs
                                 : {1'b0, voltage_code_inputs[`CODE_LOW_W-1:0]};
   assign no_code  = (voltage_code_inputs[`CODE_LOW_W-1:0] == `NO_CODE_LOW);

   // the strap is not latched yet in the start cycle, so the start code reads it directly
   assign code_init = (dac_table_select == `TABLE_FINE) ? voltage_code_inputs
                                                      : {1'b0, voltage_code_inputs[`CODE_LOW_W-1:0]};

   // sampling clock divider; rate follows the latched table select
   assign half_period = fine_mode_r ? HALF_FINE : HALF_COARSE;
   assign half_done   = (div_cnt_r == half_period);
   assign rise_evt    = half_done & ~code_sampling_clock_r;
   assign fall_evt    = half_done & code_sampling_clock_r;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_cnt_r             <= {`DIV_W{1'b0}};
         code_sampling_clock_r <= 1'b0;
      end else if (half_done) begin
         div_cnt_r             <= {`DIV_W{1'b0}};
         code_sampling_clock_r <= ~code_sampling_clock_r;
      end else begin
         div_cnt_r             <= div_cnt_r + {{(`DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // table select is a strap: caught in the first cycle after reset, not under it
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         fine_mode_r <= 1'b1;
      end else if (state_r == ST_INIT) begin
         fine_mode_r <= (dac_table_select == `TABLE_FINE);
      end
   end

   // step size follows the latched table
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         step_size_uv_r <= `STEP_FINE_UV;
      end else begin
         step_size_uv_r <= fine_mode_r ? `STEP_FINE_UV : `STEP_COARSE_UV;
      end
   end

   // a grounded pin reads zero, so zero on bit five selects the offset; follows the pin live
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ref_offset_uv_r <= `OFFSET_NONE_UV;
      end else if (!fine_mode_r && !voltage_code_inputs[`OFFSET_BIT]) begin
         ref_offset_uv_r <= `OFFSET_COARSE_UV;
      end else begin
         ref_offset_uv_r <= `OFFSET_NONE_UV;
      end
   end

   // shutdown code seen one edge ago; the exit is judged against it
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         no_code_r <= 1'b0;
      end else begin
         no_code_r <= no_code;
      end
   end

   // switches stay off under reset, in the start cycle and while the shutdown code stands
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         switches_enable_r <= 1'b0;
      end else begin
         switches_enable_r <= ~no_code & (state_r != ST_INIT);
      end
   end

   // one pulse when the code leaves shutdown; soft start outside the block takes over
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         restart_pulse_r <= 1'b0;
      end else begin
         restart_pulse_r <= no_code_r & ~no_code;
      end
   end

   assign soft_start_done = soft_start_done_in & switches_enable_r;

   // protections are only live outside a transition
   assign over_voltage_protect_en  = ~transition_active_r;
   assign under_voltage_protect_en = ~transition_active_r;

   // step direction, next value and arrival, shared by the sequencer processes
   assign step_up     = (target_code_r > ref_code_r);
   assign ref_stepped = step_up ? ref_code_r + ONE_LSB : ref_code_r - ONE_LSB;
   assign at_target   = (ref_stepped == target_code_r);

   // sample and confirm conditions; a shutdown code is never confirmed as a target
   assign sample_ok  = rise_evt & ~no_code & (code_eff != ref_code_r);
   assign confirm_ok = fall_evt & ~no_code & (code_eff == sampled_code_r);
   assign code_exit  = no_code_r & ~no_code;

   // next state: monitor, confirm on the fall, step until the target is met
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_INIT: begin
            // start cycle only, used to load the reference and latch the strap
            state_nxt = ST_MONITOR;
         end
         ST_MONITOR: begin
            // a shutdown exit reloads instead of ramping, so it never starts a confirm
            if (!code_exit && sample_ok) begin
               state_nxt = ST_CONFIRM;
            end
         end
         ST_CONFIRM: begin
            // a code that moved between rise and fall is dropped, not followed
            if (fall_evt) begin
               state_nxt = confirm_ok ? ST_STEP : ST_MONITOR;
            end
         end
         ST_STEP: begin
            // input changes are not looked at while stepping
            if (rise_evt && at_target) begin
               state_nxt = ST_MONITOR;
            end
         end
         default: begin
            // an illegal code restarts from the start cycle
            state_nxt = ST_INIT;
         end
      endcase
   end

   // reference, target and mask flag for the next edge
   always @* begin
      ref_code_nxt    = ref_code_r;
      target_code_nxt = target_code_r;
      active_nxt      = transition_active_r;
      case (state_r)
         ST_INIT: begin
            // reference starts at the code present at release, in the strap's own table
            ref_code_nxt    = code_init;
            target_code_nxt = code_init;
         end
         ST_MONITOR: begin
            if (code_exit) begin
               // leaving shutdown restarts at the new code, no ramp here
               ref_code_nxt    = code_eff;
               target_code_nxt = code_eff;
            end
         end
         ST_CONFIRM: begin
            if (confirm_ok) begin
               // confirmed; first step lands on the next rising edge
               target_code_nxt = sampled_code_r;
               active_nxt      = 1'b1;
            end
         end
         ST_STEP: begin
            if (rise_evt) begin
               // one LSB per sampling cycle whatever the jump size
               ref_code_nxt = ref_stepped;
               if (at_target) begin
                  // reached: unmask on the edge of the last step
                  active_nxt = 1'b0;
               end
            end
         end
         default: begin
            // dropping the flag brings the protections back at once
            active_nxt = 1'b0;
         end
      endcase
   end

   // sequencer state
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= ST_INIT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // reference code; reset value is replaced in the start cycle
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ref_code_r <= {`CODE_W{1'b0}};
      end else begin
         ref_code_r <= ref_code_nxt;
      end
   end

   // confirmed target code
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         target_code_r <= {`CODE_W{1'b0}};
      end else begin
         target_code_r <= target_code_nxt;
      end
   end

   // transition flag, which also masks the protections
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         transition_active_r <= 1'b0;
      end else begin
         transition_active_r <= active_nxt;
      end
   end

   // capture on every rising sample edge while monitoring; the fall compares against it
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sampled_code_r <= {`CODE_W{1'b0}};
      end else if (state_r == ST_MONITOR && rise_evt) begin
         sampled_code_r <= code_eff;
      end
   end

endmodule

// ---- dynamic_vid_reference_stepper_sva.sv ----
`timescale 1ns/1ps
module dynamic_vid_reference_stepper_sva (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [5:0]  voltage_code_inputs,
   input wire logic [5:0]  ref_code_r,
   input wire logic [5:0]  target_code_r,
   input wire logic [15:0] step_size_uv_r,
   input wire logic [15:0] ref_offset_uv_r,
   input wire logic        transition_active_r,
   input wire logic        over_voltage_protect_en,
   input wire logic        under_voltage_protect_en,
   input wire logic        switches_enable_r,
   input wire logic        soft_start_done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // half a sampling period is at least 11 clocks in both tables
   sequence ref_hold;
      $stable(ref_code_r)[*8];
   endsequence
   prot_mask_a: assert property (over_voltage_protect_en == !transition_active_r
      && under_voltage_protect_en == !transition_active_r) else $error("protection mask wrong");
   step_dir_a: assert property (transition_active_r && $changed(ref_code_r) |-> ref_code_r ==
      (($past(ref_code_r) < target_code_r) ? $past(ref_code_r) + 6'h01 : $past(ref_code_r) - 6'h01))
      else $error("reference step wrong");
   step_gap_a: assert property (transition_active_r && $changed(ref_code_r) |=> ref_hold)
      else $error("reference stepped too fast");
   stop_equal_a: assert property ($fell(transition_active_r) |-> ref_code_r == target_code_r)
      else $error("stepping ended off target");
   target_hold_a: assert property (transition_active_r && $past(transition_active_r)
      |-> $stable(target_code_r)) else $error("target moved mid transition");
   offset_sel_a: assert property ($stable(step_size_uv_r) |-> ref_offset_uv_r ==
      ((step_size_uv_r == 16'h61a8 && !$past(voltage_code_inputs[5])) ? 16'h61a8 : 16'h0000))
      else $error("offset wrong");
   shutdown_a: assert property (voltage_code_inputs[4:0] == 5'h1f |=> !switches_enable_r)
      else $error("switches not off");
   ss_low_a: assert property (!switches_enable_r |-> !soft_start_done) else $error("done not low");
endmodule
bind dynamic_vid_reference_stepper dynamic_vid_reference_stepper_sva dynamic_vid_reference_stepper_sva_inst (
   .mclk, .rst, .voltage_code_inputs, .ref_code_r, .target_code_r, .step_size_uv_r, .ref_offset_uv_r,
   .transition_active_r, .over_voltage_protect_en, .under_voltage_protect_en, .switches_enable_r,
   .soft_start_done);

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic        mclk, rst, strap, ss_in, act, over_voltage_protect, under_voltage_protect, sw, ssd, rs, sclk;
   logic [5:0]  want, code, ref_c, tgt;
   logic [15:0] step, offs;
   int          fail_count = 0;
   int          compares = 0;
   int          n;
   // short switching period keeps each sampling half period at 11 or 33 clocks
   dynamic_vid_reference_stepper #(.FSW_KHZ(1500)) dynamic_vid_reference_stepper_inst (
      .mclk(mclk), .rst(rst), .voltage_code_inputs(code), .dac_table_select(strap),
      .soft_start_done_in(ss_in), .ref_code_r(ref_c), .target_code_r(tgt), .step_size_uv_r(step),
      .ref_offset_uv_r(offs), .transition_active_r(act), .over_voltage_protect_en(over_voltage_protect),
      .under_voltage_protect_en(under_voltage_protect), .switches_enable_r(sw), .soft_start_done(ssd),
      .restart_pulse_r(rs), .code_sampling_clock_r(sclk));
   vid_code_source vid_code_source_inst (.mclk(mclk), .want_code(want), .voltage_code_inputs(code));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task report_and_stop;
      $display("fails=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // measures one high half of the sampling clock in mclk cycles
   task half_len(input int want_len);
      int k;
      k = 0;
      for (int i = 0; i < 100 && sclk === 1'b1; i++) tick;
      for (int i = 0; i < 100 && sclk !== 1'b1; i++) tick;
      for (int i = 0; i < 100 && sclk === 1'b1; i++) begin
         tick;
         k++;
      end
      chk(k[15:0], want_len[15:0]);
   endtask
   task tick;
      @(posedge mclk);
      #1;
   endtask
   // strap is only read at the first edge after release, so each table needs its own reset
   task start(input logic s, input logic [5:0] c);
      rst = 1'b1;
      strap = s;
      want = c;
      repeat (10) tick;
      rst = 1'b0;
      repeat (3) tick;
   endtask
   // bounded wait for the stepping flag, counting reference moves on the way
   task wait_act(input logic v);
      logic [5:0] last;
      last = ref_c;
      for (int i = 0; i < 5000 && act !== v; i++) begin
         tick;
         n += (ref_c !== last);
         last = ref_c;
      end
      if (act !== v) begin
         fail_count++;
         report_and_stop;
      end
   endtask
   task move(input logic [5:0] c, input int steps);
      want = c;
      n = 0;
      wait_act(1'b1);
      chk(over_voltage_protect, 1'b0);
      chk(under_voltage_protect, 1'b0);
      wait_act(1'b0);
      chk(over_voltage_protect, 1'b1);
      chk(under_voltage_protect, 1'b1);
      chk(ref_c, c);
      chk(n[15:0], steps[15:0]);
   endtask
   task fine_mode;
      chk(step, 16'h30d4);
      half_len(11);
      move(6'h15, 5);
      move(6'h10, 5);
      want = 6'h20;
      wait_act(1'b1);
      // two sampling periods after the flag rises, still well inside the ramp
      repeat (44) tick;
      want = 6'h22; // arrives while stepping, must be left alone
      wait_act(1'b0);
      chk(tgt, 6'h20);
      move(6'h22, 2);
   endtask
   task coarse_mode;
      start(1'b0, 6'h0a);
      chk(step, 16'h61a8);
      chk(offs, 16'h61a8);
      move(6'h0d, 3);
      half_len(33);
      move(6'h08, 5);
      // bit five open: same low code, no offset and no transition
      want = 6'h28;
      repeat (3) tick;
      chk(offs, 16'h0000);
      repeat (132) tick;
   endtask
   task shutdown;
      int k;
      k = 0;
      want = 6'h1f;
      repeat (4) tick;
      chk(sw, 1'b0);
      chk(ssd, 1'b0);
      want = 6'h0c;
      repeat (6) begin
         tick;
         k += rs;
      end
      chk(k[15:0], 16'h1);
      chk(ref_c, 6'h0c);
      chk(sw, 1'b1);
   endtask
   initial begin
      ss_in = 1'b1;
      start(1'b1, 6'h10);
      fine_mode;
      coarse_mode;
      shutdown;
      report_and_stop;
   end
endmodule

// ---- vid_code_source.sv ----
`timescale 1ns/1ps
// processor side of the code pins; the bench decides when a new code goes out
module vid_code_source (
   input  wire logic       mclk,
   input  wire logic [5:0] want_code,
   output logic      [5:0] voltage_code_inputs
);
   // pins change just after an edge; a one reads as an open pin, pacing is up to the caller
   always @(posedge mclk) voltage_code_inputs <= want_code;
endmodule

// ---- vid_stepper_consts.vh ----
`ifndef VID_STEPPER_CONSTS_VH
`define VID_STEPPER_CONSTS_VH

// system clock rate and default per-phase switching rate, in kHz
`define CLK_KHZ          100000
`define FSW_KHZ_DEFAULT  150

// sampling clock multiplier over the switching rate, per table
`define FINE_CLK_MULT    3
`define COARSE_CLK_MULT  1

// reference step sizes and built-in offset, in microvolts
`define STEP_FINE_UV     16'h30d4
`define STEP_COARSE_UV   16'h61a8
`define OFFSET_COARSE_UV 16'h61a8
`define OFFSET_NONE_UV   16'h0000

// code layout
`define CODE_W           6
`define CODE_LOW_W       5
`define OFFSET_BIT       5
`define NO_CODE_LOW      5'h1f

// table select strap levels (pin open reads one through the pull-up)
`define TABLE_FINE       1'b1
`define TABLE_COARSE     1'b0

// width of the sampling clock half-period counter
`define DIV_W            16

`endif
